// File: rtl/gpp_port.sv
// General purpose I/O port with APB registers and two clock outputs
//
// Chosen here: the APB slave port and the address map.
module gpp_port
  import gpp_pkg::*;
(
  // Clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [gpp_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Pins
  input wire logic [gpp_pkg::PIN_W-1:0] gpio_in,
  output logic [gpp_pkg::PIN_W-1:0] gpio_out,
  output logic [gpp_pkg::PIN_W-1:0] gpio_oe,
  // Interrupt
  output logic irq
);
  import gpp_pkg::*;

  function automatic logic [DIV_W-1:0] gpp_lim(input logic [DIV_W-1:0] v);
    gpp_lim = (v < MIN_PHASE_CYC) ? MIN_PHASE_CYC : v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  logic [PIN_W-1:0] data_reg, data_next;
  logic [PIN_W-1:0] dir_reg, dir_next;
  logic [IRQ_W-1:0] ien_reg, ien_next;
  logic [IRQ_W-1:0] stat_reg, stat_next;
  logic [1:0] mode_reg, mode_next;
  logic [15:0] div_reg [2];
  logic [15:0] div_next [2];
  logic [PIN_W-1:0] sync1_reg, sync2_reg, prev_reg;
  logic [DIV_W-1:0] cnt_reg [2];
  logic [DIV_W-1:0] cnt_next [2];
  logic [1:0] phase_reg, phase_next;
  logic [PIN_W-1:0] out_reg, out_next, oe_reg, oe_next;
  logic [31:0] rd_reg, rd_next;
  logic wr, rd_setup, addr_ok;
  logic [IRQ_W-1:0] events, clr;

  ////////////////////////////////////////////////////////////////////////
  // Bus decode; zero wait states
  assign pready = 1'b1;
  assign wr = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  always_comb
  begin
    case (paddr)
      OFS_DATA, OFS_DIR, OFS_IN, OFS_IEN, OFS_STAT, OFS_CLR,
      OFS_CLKCTL, OFS_DIV14, OFS_DIV15: addr_ok = 1'b1;
      default: addr_ok = 1'b0;
    endcase
  end
  assign pslverr = psel & penable & ~addr_ok;

  // Rising edges on inputs; only the second stage feeds logic
  assign events = sync2_reg[IRQ_W-1:0] & ~prev_reg[IRQ_W-1:0] & ~dir_reg[IRQ_W-1:0];
  assign clr = (wr && paddr == OFS_CLR) ? pwdata[IRQ_W-1:0] : '0;

  always_comb
  begin
    data_next = data_reg;
    dir_next = dir_reg;
    ien_next = ien_reg;
    mode_next = mode_reg;
    div_next[0] = div_reg[0];
    div_next[1] = div_reg[1];
    if (wr)
    begin
      case (paddr)
        OFS_DATA: data_next = pwdata[PIN_W-1:0];
        OFS_DIR: dir_next = pwdata[PIN_W-1:0];
        OFS_IEN: ien_next = pwdata[IRQ_W-1:0];
        OFS_CLKCTL: mode_next = pwdata[1:0];
        OFS_DIV14: div_next[0] = pwdata[15:0];
        OFS_DIV15: div_next[1] = pwdata[15:0];
        default: data_next = data_reg;
      endcase
    end
    // Set wins over a clear in the same cycle
    stat_next = (stat_reg & ~clr) | events;
  end

  always_comb
  begin
    rd_next = rd_reg;
    if (rd_setup)
    begin
      case (paddr)
        OFS_DATA: rd_next = {16'h0000, data_reg};
        OFS_DIR: rd_next = {16'h0000, dir_reg};
        OFS_IN: rd_next = {16'h0000, sync2_reg};
        OFS_IEN: rd_next = {19'h0, ien_reg};
        OFS_STAT: rd_next = {19'h0, stat_reg};
        OFS_CLKCTL: rd_next = {30'h0, mode_reg};
        OFS_DIV14: rd_next = {16'h0000, div_reg[0]};
        OFS_DIV15: rd_next = {16'h0000, div_reg[1]};
        default: rd_next = 32'h00000000;
      endcase
    end
  end
  assign prdata = rd_reg;
  assign irq = |(stat_reg & ien_reg);

  ////////////////////////////////////////////////////////////////////////
  // Clock dividers; index 0 feeds pin 14, index 1 pin 15
  always_comb
  begin
    logic [DIV_W-1:0] lim;
    lim = '0;
    for (int i = 0; i < 2; i++)
    begin
      lim = phase_reg[i] ? gpp_lim(div_reg[i][DIV_HI_LSB +: DIV_W])
                         : gpp_lim(div_reg[i][DIV_LO_LSB +: DIV_W]);
      if (!mode_reg[i])
      begin
        cnt_next[i] = '0;
        phase_next[i] = 1'b0;
      end
      else if (cnt_reg[i] >= lim - 8'h01)
      begin
        cnt_next[i] = '0;
        phase_next[i] = ~phase_reg[i];
      end
      else
      begin
        cnt_next[i] = cnt_reg[i] + 8'h01;
        phase_next[i] = phase_reg[i];
      end
    end
  end

  // Pin drive; clock mode replaces the data bit, direction still gates
  always_comb
  begin
    out_next = data_reg;
    if (mode_reg[CK14])
      out_next[PIN14] = phase_reg[CK14];
    if (mode_reg[CK15])
      out_next[PIN15] = phase_reg[CK15];
    oe_next = dir_reg;
  end
  assign gpio_out = out_reg;
  assign gpio_oe = oe_reg;

  ////////////////////////////////////////////////////////////////////////
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      data_reg <= DATA_RST;
      dir_reg <= DIR_RST;
      ien_reg <= IEN_RST;
      stat_reg <= '0;
      mode_reg <= CLKCTL_RST;
      div_reg[0] <= {DIV_LO_RST, DIV_HI_RST};
      div_reg[1] <= {DIV_LO_RST, DIV_HI_RST};
      // Pull-up level, so leaving reset shows no false rising edge
      sync1_reg <= '1;
      sync2_reg <= '1;
      prev_reg <= '1;
      cnt_reg[0] <= '0;
      cnt_reg[1] <= '0;
      phase_reg <= '0;
      out_reg <= DATA_RST;
      oe_reg <= DIR_RST;
      rd_reg <= 32'h00000000;
    end
    else
    begin
      data_reg <= data_next;
      dir_reg <= dir_next;
      ien_reg <= ien_next;
      stat_reg <= stat_next;
      mode_reg <= mode_next;
      div_reg[0] <= div_next[0];
      div_reg[1] <= div_next[1];
      sync1_reg <= gpio_in;
      sync2_reg <= sync1_reg;
      prev_reg <= sync2_reg;
      cnt_reg[0] <= cnt_next[0];
      cnt_reg[1] <= cnt_next[1];
      phase_reg <= phase_next;
      out_reg <= out_next;
      oe_reg <= oe_next;
      rd_reg <= rd_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Checks; first_reg marks the first cycle after reset release
  logic first_reg;
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      first_reg <= 1'b1;
    else
      first_reg <= 1'b0;
  end

  property p_dir_drive;
    @(posedge pclk) disable iff (!presetn)
    wr && paddr == OFS_DIR |=> ##1 gpio_oe == $past(pwdata[PIN_W-1:0], 2);
  endproperty
  a_dir_drive: assert property (p_dir_drive) else $error("oe not following direction");

  property p_irq_src;
    @(posedge pclk) disable iff (!presetn)
    events[0] |=> stat_reg[0] && (ien_reg[0] -> irq);
  endproperty
  a_irq_src: assert property (p_irq_src) else $error("input edge lost");

  property p_reset_in;
    @(posedge pclk) disable iff (!presetn)
    first_reg |-> gpio_oe[13:0] == 14'h0000 && gpio_oe[PIN15];
  endproperty
  a_reset_in: assert property (p_reset_in) else $error("pins driven after reset");

  property p_pin14_clk;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK14] && $stable(mode_reg[CK14]) |=> gpio_out[PIN14] == $past(phase_reg[CK14]);
  endproperty
  a_pin14_clk: assert property (p_pin14_clk) else $error("pin 14 clock wrong");

  property p_phase_len;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK15] && phase_reg[CK15] && cnt_reg[1] < gpp_lim(div_reg[1][DIV_HI_LSB +: DIV_W]) - 8'h01
      && $stable(div_reg[1]) |=> phase_reg[CK15] || !mode_reg[CK15];
  endproperty
  a_phase_len: assert property (p_phase_len) else $error("high phase cut short");

  property p_rst14;
    @(posedge pclk) disable iff (!presetn)
    first_reg |-> !mode_reg[CK14] && !gpio_oe[PIN14];
  endproperty
  a_rst14: assert property (p_rst14) else $error("pin 14 not input at reset");

  property p_rst15;
    @(posedge pclk) disable iff (!presetn)
    first_reg |-> mode_reg[CK15] ##[1:4] gpio_out[PIN15];
  endproperty
  a_rst15: assert property (p_rst15) else $error("pin 15 clock not running");

  // Software may stop the clock; leaving clock mode ends the wait
  property p_clk15_live;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK15] && gpio_oe[PIN15] && $stable(mode_reg)
      |-> ##[1:300] ($changed(gpio_out[PIN15]) || !mode_reg[CK15]);
  endproperty
  a_clk15_live: assert property (p_clk15_live) else $error("pin 15 clock stalled");

  property p_div_toggle;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK14] && mode_next[CK14] && !phase_reg[CK14]
      && cnt_reg[0] == gpp_lim(div_reg[0][DIV_LO_LSB +: DIV_W]) - 8'h01
      |=> phase_reg[CK14] && cnt_reg[0] == 8'h00;
  endproperty
  a_div_toggle: assert property (p_div_toggle) else $error("divider did not toggle");

  property p_pin15_clk;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK15] && $stable(mode_reg[CK15]) |=> gpio_out[PIN15] == $past(phase_reg[CK15]);
  endproperty
  a_pin15_clk: assert property (p_pin15_clk) else $error("pin 15 clock wrong");

  // Low phase of the pin 15 divider lasts its programmed count
  property p_low_len;
    @(posedge pclk) disable iff (!presetn)
    mode_reg[CK15] && !phase_reg[CK15]
      && cnt_reg[1] < gpp_lim(div_reg[1][DIV_LO_LSB +: DIV_W]) - 8'h01
      |=> !phase_reg[CK15];
  endproperty
  a_low_len: assert property (p_low_len) else $error("low phase cut short");

  // A new edge must survive a clear of the same bit
  property p_set_wins;
    @(posedge pclk) disable iff (!presetn)
    (events & clr) != '0
      |=> (stat_reg & $past(events) & $past(clr)) == ($past(events) & $past(clr));
  endproperty
  a_set_wins: assert property (p_set_wins) else $error("clear beat a new edge");

  property p_out_no_event;
    @(posedge pclk) disable iff (!presetn)
    dir_reg[IRQ_W-1:0] != '0
      |=> (stat_reg & ~$past(stat_reg) & $past(dir_reg[IRQ_W-1:0])) == '0;
  endproperty
  a_out_no_event: assert property (p_out_no_event) else $error("event on output pin");

  property p_clk14_gated;
    @(posedge pclk) disable iff (!presetn)
    !dir_reg[PIN14] |=> !gpio_oe[PIN14];
  endproperty
  a_clk14_gated: assert property (p_clk14_gated) else $error("pin 14 driven as input");
endmodule

// File: rtl/gpp_pkg.sv
// Constants for the general purpose I/O port
package gpp_pkg;
  localparam int PIN_W = 16;
  localparam int IRQ_W = 13;
  localparam int DIV_W = 8;
  localparam int ADDR_W = 8;
  // Register byte offsets
  localparam logic [7:0] OFS_DATA = 8'h00;
  localparam logic [7:0] OFS_DIR = 8'h04;
  localparam logic [7:0] OFS_IN = 8'h08;
  localparam logic [7:0] OFS_IEN = 8'h0C;
  localparam logic [7:0] OFS_STAT = 8'h10;
  localparam logic [7:0] OFS_CLR = 8'h14;
  localparam logic [7:0] OFS_CLKCTL = 8'h18;
  localparam logic [7:0] OFS_DIV14 = 8'h1C;
  localparam logic [7:0] OFS_DIV15 = 8'h20;
  // Reset values
  localparam logic [15:0] DATA_RST = 16'h0000;
  localparam logic [15:0] DIR_RST = 16'h8000;
  localparam logic [12:0] IEN_RST = 13'h0000;
  localparam logic [1:0] CLKCTL_RST = 2'h2;
  localparam logic [7:0] DIV_HI_RST = 8'h01;
  localparam logic [7:0] DIV_LO_RST = 8'h01;
  // Field positions
  localparam int DIV_HI_LSB = 0;
  localparam int DIV_LO_LSB = 8;
  localparam int CK14 = 0;
  localparam int CK15 = 1;
  localparam int PIN14 = 14;
  localparam int PIN15 = 15;
  // Timing
  localparam int PCLK_HZ = 20000000;
  localparam int CLK_MAX_HZ = 33330000;
  localparam int MIN_PHASE_RAW = (PCLK_HZ + 2 * CLK_MAX_HZ - 1) / (2 * CLK_MAX_HZ);
  localparam logic [7:0] MIN_PHASE_CYC = (MIN_PHASE_RAW < 1) ? 8'h01 : 8'(MIN_PHASE_RAW);
endpackage

// File: verif/gpp_board.sv
// Board model on the pin side: pull-ups, external drivers, bus clock counter
module gpp_board
  import gpp_pkg::*;
(
  // Port side
  input wire logic [gpp_pkg::PIN_W-1:0] gpio_out,
  input wire logic [gpp_pkg::PIN_W-1:0] gpio_oe,
  output logic [gpp_pkg::PIN_W-1:0] gpio_in,
  // Bench control
  input wire logic [gpp_pkg::PIN_W-1:0] ext_oe,
  input wire logic [gpp_pkg::PIN_W-1:0] ext_val,
  output int bus_clk_edges
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [PIN_W-1:0] lvl;
  // Pull-up wins only when nobody drives; the port overrides the board
  always_comb
  begin
    for (int i = 0; i < PIN_W; i++)
      lvl[i] = gpio_oe[i] ? gpio_out[i] : (ext_oe[i] ? ext_val[i] : 1'b1);
  end
  assign gpio_in = lvl;
  // Expansion bus timed by pin 15
  initial
  begin
    bus_clk_edges = 0;
    forever @(posedge lvl[PIN15]) bus_clk_edges++;
  end
endmodule

// File: verif/tb_gpp_port.sv
// Self-checking testbench for the general purpose I/O port
module tb_gpp_port
  import gpp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [PIN_W-1:0] gpio_in, gpio_out, gpio_oe, ext_oe, ext_val;
  int bus_clk_edges, err_count, samples_checked, e0;
  logic [31:0] h;
  gpp_port u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .gpio_in(gpio_in), .gpio_out(gpio_out), .gpio_oe(gpio_oe), .irq(irq));
  gpp_board u_board (.gpio_out(gpio_out), .gpio_oe(gpio_oe), .gpio_in(gpio_in),
    .ext_oe(ext_oe), .ext_val(ext_val), .bus_clk_edges(bus_clk_edges));
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic chk(input logic [31:0] g, input logic [31:0] x);
    samples_checked++;
    if (g !== x)
    begin
      err_count++;
      $display("[ERR] %0t got %h exp %h", $time, g, x);
    end
  endtask
  // Waits on pready with no assumed latency; bench timeout ends a hang
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0000_0000);
    chk(q, x);
  endtask
  // Pin highs and pin 15 clock edges over n settled cycles
  task automatic highs(input int b, input int n);
    h = 0;
    e0 = bus_clk_edges;
    repeat (n)
    begin
      @(negedge pclk);
      h += gpio_out[b];
    end
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #250000;
    err_count++;
    complete_run();
  end
  initial
  begin
    presetn = 1'b0;
    {psel, penable, pwrite} = 3'h0;
    paddr = 8'h00;
    pwdata = 32'h0000_0000;
    ext_oe = 16'h3FFF;
    ext_val = 16'h0000;
    repeat (16) @(negedge pclk);
    chk(32'(gpio_oe), 32'h0000_8000);
    chk(32'({irq, gpio_out}), 32'h0000_0000);
    @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_DIR, 32'h0000_8000);
    rd(OFS_CLKCTL, 32'h0000_0002);
    rd(OFS_DIV15, 32'h0000_0101);
    highs(PIN15, 20);
    chk(h, 32'h0000_000A);
    chk(bus_clk_edges - e0, 32'h0000_000A);
    // Two high, three low: one fifth of the duty gone
    apb(1'b1, OFS_DIV15, 32'h0000_0302);
    repeat (10) @(negedge pclk);
    highs(PIN15, 25);
    chk(h, 32'h0000_000A);
    chk(bus_clk_edges - e0, 32'h0000_0005);
    apb(1'b1, OFS_IEN, 32'h0000_0008);
    rd(OFS_IEN, 32'h0000_0008);
    @(posedge pclk);
    ext_val <= 16'h2028;
    repeat (6) @(negedge pclk);
    rd(OFS_STAT, 32'h0000_0028);
    chk(32'(irq), 32'h0000_0001);
    apb(1'b1, OFS_CLR, 32'h0000_0008);
    repeat (2) @(negedge pclk);
    chk(32'(irq), 32'h0000_0000);
    rd(OFS_STAT, 32'h0000_0020);
    apb(1'b1, OFS_DATA, 32'h0000_40A0);
    apb(1'b1, OFS_DIR, 32'h0000_C0F0);
    rd(OFS_DATA, 32'h0000_40A0);
    repeat (3) @(negedge pclk);
    chk(32'(gpio_oe), 32'h0000_C0F0);
    chk(32'(gpio_out[14:0]), 32'h0000_40A0);
    apb(1'b1, OFS_CLKCTL, 32'h0000_0001);
    apb(1'b1, OFS_DIV14, 32'h0000_0101);
    repeat (5) @(negedge pclk);
    highs(PIN14, 20);
    chk(h, 32'h0000_000A);
    chk(bus_clk_edges - e0, 32'h0000_0000);
    apb(1'b1, OFS_DIR, 32'h0000_0000);
    repeat (3) @(negedge pclk);
    chk(32'(gpio_oe), 32'h0000_0000);
    rd(OFS_IN, 32'h0000_E028);
    rd(8'h40, 32'h0000_0000);
    chk(32'(e), 32'h0000_0001);
    complete_run();
  end
endmodule
